// >>> design/psfm_ctrl.sv
// Pump staging and emergency (fire) mode control for a speed drive.
// Assumes synchronous inputs, a 200 MHz clock and speeds in 0.1 Hz units.
//
// Operation
// - start next pump above start speed, settled
// - block switching until settle time elapses
// - start available pump with least run time
// - stop one running pump below stop speed
// - clamp stop speed between zero and start
// - stop running pump with most run time
// - keep per-pump run time; clear input
// - emergency input polarity selects active level
// - modes 4, 8, 13 use digital input 2
// - mode 0 uses the user-chosen source
// - emergency suppresses listed protection trips
// - emergency bus/current trips auto reset, restart
// - zero emergency speed keeps normal control
// - nonzero speed forces speed; obeys safe torque off
// - never exceed assist unit count, clamped to 1..4, save for one cycle when a stop meets a cut in the count
`include "psfm_params.svh"
`default_nettype none

module psfm_ctrl (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     staging_enable,
    input  wire logic [15:0]              output_speed,
    input  wire logic [15:0]              assist_start_speed,
    input  wire logic [15:0]              assist_stop_speed,
    input  wire logic [9:0]               staging_settle_time,
    input  wire logic                     run_time_counter_clear,
    input  wire logic [2:0]               assist_unit_count,
    input  wire logic                     emergency_input_polarity,
    input  wire logic [15:0]              emergency_speed_setting,
    input  wire logic [3:0]               control_mode_select,
    input  wire logic                     digital_input_2,
    input  wire logic                     emergency_input_source,
    input  wire logic                     safe_torque_off_input,
    input  wire logic                     normal_run_cmd,
    input  wire logic [15:0]              normal_speed_ref,
    input  wire logic [`PSFM_TRIP_W-1:0]  trip_request,
    output logic [3:0]                    pump_on_q,
    output logic                          emergency_active_q,
    output logic                          settled_q,
    output logic                          run_cmd_q,
    output logic [15:0]                   speed_ref_q,
    output logic [`PSFM_TRIP_W-1:0]       trip_active_q,
    output logic                          auto_restart_q
);
    import psfm_pkg::*;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [2:0] pop4(input logic [3:0] v);
        pop4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
             + {2'b00, v[3]};
    endfunction

    // ------------------------------------------------------------
    // Seconds time base
    // ------------------------------------------------------------
    // One pulse per second; run times and settling advance only on it
    logic [27:0] tick_cnt_q;
    logic        tick_q;
    wire         tick_wrap = (tick_cnt_q == 28'(`PSFM_TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!resetn) begin
            tick_cnt_q <= 28'h000_0000;
            tick_q     <= 1'b0;
        end else begin
            tick_cnt_q <= tick_wrap ? 28'h000_0000 : tick_cnt_q + 28'h1;
            tick_q     <= tick_wrap;
        end
    end

    // ------------------------------------------------------------
    // Configuration clamps
    // ------------------------------------------------------------
    // Stop speed above start would make staging oscillate
    wire [15:0] stop_lim = (assist_stop_speed > assist_start_speed)
                         ? assist_start_speed : assist_stop_speed;
    wire [9:0]  settle_lim =
        (staging_settle_time < `PSFM_SETTLE_MIN_S) ? `PSFM_SETTLE_MIN_S :
        (staging_settle_time > `PSFM_SETTLE_MAX_S) ? `PSFM_SETTLE_MAX_S :
        staging_settle_time;
    wire [2:0]  units_lim =
        (assist_unit_count < `PSFM_UNITS_MIN) ? `PSFM_UNITS_MIN :
        (assist_unit_count > `PSFM_UNITS_MAX) ? `PSFM_UNITS_MAX :
        assist_unit_count;

    // ------------------------------------------------------------
    // Run time counters and pump choice
    // ------------------------------------------------------------
    logic [`PSFM_RUNTIME_W-1:0] run_time_q [4];
    logic [3:0] avail;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pump
            assign avail[g] = (3'(g) < units_lim);
            always_ff @(posedge clk) begin
                if (!resetn || run_time_counter_clear)
                    run_time_q[g] <= '0;
                else if (tick_q && pump_on_q[g])
                    run_time_q[g] <= run_time_q[g] + 32'h0000_0001;
            end
        end
    endgenerate

    // Lowest index wins ties so the choice is deterministic
    logic [1:0] on_idx, off_idx;
    logic       on_found, off_found;
    always_comb begin
        on_idx = 2'd0;
        off_idx = 2'd0;
        on_found = 1'b0;
        off_found = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (avail[i] && !pump_on_q[i] && (!on_found ||
                run_time_q[i] < run_time_q[on_idx])) begin
                on_idx = 2'(i);
                on_found = 1'b1;
            end
            if (pump_on_q[i] && (!off_found ||
                run_time_q[i] > run_time_q[off_idx])) begin
                off_idx = 2'(i);
                off_found = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Staging state machine
    // ------------------------------------------------------------
    psfm_state_t state_q;
    logic [9:0]  settle_cnt_q;
    wire [2:0]   running = pop4(pump_on_q);
    wire         want_on  = staging_enable
                          && (output_speed > assist_start_speed)
                          && on_found && (running < units_lim);
    wire         want_off = staging_enable && (output_speed < stop_lim)
                          && off_found;
    wire         do_on    = settled_q && want_on;
    wire         do_off   = settled_q && !want_on && want_off;
    wire         settle_done = tick_q && (settle_cnt_q + 10'h1 >= settle_lim);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q      <= PSFM_IDLE;
            pump_on_q    <= 4'h0;
            settled_q    <= 1'b1;
            settle_cnt_q <= 10'h000;
        end else begin
            case (state_q)
                PSFM_IDLE: begin
                    if (do_on || do_off) begin
                        pump_on_q    <= do_on ? (pump_on_q | (4'h1 << on_idx))
                                      : (pump_on_q & ~(4'h1 << off_idx));
                        settled_q    <= 1'b0;
                        settle_cnt_q <= 10'h000;
                        state_q      <= PSFM_SETTLE;
                    end
                    // Units dropped from the count are shed at once
                    else pump_on_q <= pump_on_q & avail;
                end
                PSFM_SETTLE: begin
                    pump_on_q <= pump_on_q & avail;
                    if (settle_done) begin
                        settled_q <= 1'b1;
                        state_q   <= PSFM_IDLE;
                    end else if (tick_q)
                        settle_cnt_q <= settle_cnt_q + 10'h1;
                end
                default: state_q <= PSFM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Emergency mode
    // ------------------------------------------------------------
    wire mode_term = (control_mode_select == `PSFM_MODE_TERM_A)
                  || (control_mode_select == `PSFM_MODE_TERM_B)
                  || (control_mode_select == `PSFM_MODE_TERM_C);
    wire mode_user = (control_mode_select == `PSFM_MODE_USER);
    wire raw_in = mode_term ? digital_input_2
                : emergency_input_source;
    // Polarity 0: closing activates; 1: opening activates
    wire emer_in = (mode_term || mode_user)
                && (raw_in ^ emergency_input_polarity);
    wire forced = emergency_active_q && (emergency_speed_setting != 16'h0000);

    wire [`PSFM_TRIP_W-1:0] trip_mask = emergency_active_q
        ? ~`PSFM_SUPPRESS_MASK : {`PSFM_TRIP_W{1'b1}};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            emergency_active_q <= 1'b0;
            run_cmd_q          <= 1'b0;
            speed_ref_q        <= 16'h0000;
            trip_active_q      <= '0;
            auto_restart_q     <= 1'b0;
        end else begin
            emergency_active_q <= emer_in;
            if (safe_torque_off_input) begin
                run_cmd_q   <= 1'b0;
                speed_ref_q <= 16'h0000;
            end else if (forced) begin
                run_cmd_q   <= 1'b1;
                speed_ref_q <= emergency_speed_setting;
            end else begin
                run_cmd_q   <= normal_run_cmd;
                speed_ref_q <= normal_speed_ref;
            end
            trip_active_q  <= trip_request & trip_mask;
            auto_restart_q <= emergency_active_q
                && |(trip_request & `PSFM_RESTART_MASK);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Count judged against last edge's limit: shedding takes one edge
    never_exceed_a: assert property (@(posedge clk) disable iff (!resetn)
        pop4(pump_on_q) <= $past(units_lim))
        else $error("too many units running");
    one_change_a: assert property (@(posedge clk) disable iff (!resetn)
        (state_q == PSFM_SETTLE) |=> $countones(pump_on_q)
            <= $countones($past(pump_on_q)))
        else $error("pump started while settling");
    start_sel_a: assert property (@(posedge clk) disable iff (!resetn)
        do_on |=> pump_on_q[$past(on_idx)] && !settled_q)
        else $error("start not applied");
    least_time_a: assert property (@(posedge clk) disable iff (!resetn)
        do_on |-> run_time_q[on_idx] <= run_time_q[(on_idx + 2'd1)]
            || !avail[(on_idx + 2'd1)] || pump_on_q[(on_idx + 2'd1)])
        else $error("start choice not least");
    stop_sel_a: assert property (@(posedge clk) disable iff (!resetn)
        do_off |=> !pump_on_q[$past(off_idx)])
        else $error("stop not applied");
    most_time_a: assert property (@(posedge clk) disable iff (!resetn)
        do_off |-> run_time_q[off_idx] >= run_time_q[(off_idx + 2'd1)]
            || !pump_on_q[(off_idx + 2'd1)])
        else $error("stop choice not most");
    clear_time_a: assert property (@(posedge clk) disable iff (!resetn)
        run_time_counter_clear |=> run_time_q[0] == '0)
        else $error("run time not cleared");
    polarity_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode_term && (digital_input_2 ^ emergency_input_polarity))
            |=> emergency_active_q)
        else $error("emergency input not honoured");
    suppress_a: assert property (@(posedge clk) disable iff (!resetn)
        emergency_active_q |=> (trip_active_q & `PSFM_SUPPRESS_MASK) == '0)
        else $error("trip not suppressed");
    forced_speed_a: assert property (@(posedge clk) disable iff (!resetn)
        (forced && !safe_torque_off_input)
            |=> run_cmd_q && speed_ref_q == $past(emergency_speed_setting))
        else $error("forced speed not applied");
    torque_off_a: assert property (@(posedge clk) disable iff (!resetn)
        safe_torque_off_input |=> !run_cmd_q)
        else $error("safe torque off not obeyed");
    reset_state_a: assert property (@(posedge clk)
        !resetn |=> pump_on_q == 4'h0 && settled_q && !emergency_active_q)
        else $error("reset state wrong");
    // Control path checks look at the raw inputs; all but stop_clamp_a one edge back
    stop_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
        do_off |-> output_speed < assist_start_speed
            && output_speed < assist_stop_speed)
        else $error("stop above clamped limit");
    settle_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        (do_on || do_off) |=> settle_cnt_q == 10'h000 && !settled_q)
        else $error("settle timer not restarted");
    user_source_a: assert property (@(posedge clk) disable iff (!resetn)
        (mode_user && (emergency_input_source ^ emergency_input_polarity))
            |=> emergency_active_q)
        else $error("user emergency source ignored");
    no_source_a: assert property (@(posedge clk) disable iff (!resetn)
        !(mode_term || mode_user) |=> !emergency_active_q)
        else $error("emergency without a source");
    auto_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        (emergency_active_q && |(trip_request & `PSFM_RESTART_MASK))
            |=> auto_restart_q && |(trip_active_q & `PSFM_RESTART_MASK))
        else $error("restart trip not flagged");
    normal_ctrl_a: assert property (@(posedge clk) disable iff (!resetn)
        (!forced && !safe_torque_off_input)
            |=> run_cmd_q == $past(normal_run_cmd)
            && speed_ref_q == $past(normal_speed_ref))
        else $error("normal control not followed");

    start_cov: cover property (@(posedge clk) disable iff (!resetn) do_on);
    stop_cov: cover property (@(posedge clk) disable iff (!resetn) do_off);
    settle_cov: cover property (@(posedge clk) disable iff (!resetn)
        (state_q == PSFM_SETTLE) ##1 settled_q);
    emer_cov: cover property (@(posedge clk) disable iff (!resetn) forced);
    restart_cov: cover property (@(posedge clk) disable iff (!resetn)
        auto_restart_q);
endmodule

`default_nettype wire

// >>> pkg/psfm_params.svh
// Constants for the pump staging and emergency mode controller.
// Assumes a 200 MHz system clock; speeds are unsigned 0.1 Hz units.
`ifndef PSFM_PARAMS_SVH
`define PSFM_PARAMS_SVH

`define PSFM_CLK_HZ          200000000
`define PSFM_TICK_PERIOD_S   1
`define PSFM_TICK_CYCLES     (`PSFM_CLK_HZ * `PSFM_TICK_PERIOD_S)
`define PSFM_SETTLE_MIN_S    10'h002
`define PSFM_SETTLE_MAX_S    10'h258
`define PSFM_SETTLE_DEF_S    10'h03C
`define PSFM_STOP_DEF_SPEED  16'h012C
`define PSFM_UNITS_MIN       3'h1
`define PSFM_UNITS_MAX       3'h4
`define PSFM_MODE_TERM_A     4'h4
`define PSFM_MODE_TERM_B     4'h8
`define PSFM_MODE_TERM_C     4'hD
`define PSFM_MODE_USER       4'h0
`define PSFM_RUNTIME_W       32
`define PSFM_TRIP_W          14

// Trip vector bit positions
`define PSFM_TRIP_HS_OVER_T   0
`define PSFM_TRIP_HS_UNDER_T  1
`define PSFM_TRIP_THERMISTOR  2
`define PSFM_TRIP_EXTERNAL    3
`define PSFM_TRIP_LOOP_LOSS   4
`define PSFM_TRIP_PHASE_IMB   5
`define PSFM_TRIP_PHASE_LOSS  6
`define PSFM_TRIP_COMMS_LOSS  7
`define PSFM_TRIP_OVERLOAD    8
`define PSFM_TRIP_BUS_OVER_V  9
`define PSFM_TRIP_BUS_UNDER_V 10
`define PSFM_TRIP_FAST_OC     11
`define PSFM_TRIP_INST_OC     12
`define PSFM_TRIP_OUT_STAGE   13
`define PSFM_SUPPRESS_MASK    14'h01FF
`define PSFM_RESTART_MASK     14'h3E00

`endif

// >>> pkg/psfm_pkg.sv
// Types for the pump staging and emergency mode controller.
// Assumes psfm_params.svh sits on the include path.
`default_nettype none
package psfm_pkg;
    typedef enum logic [1:0] {
        PSFM_IDLE,
        PSFM_SETTLE
    } psfm_state_t;
    typedef logic [3:0] psfm_mask_t;
endpackage
`default_nettype wire

// >>> tb/psfm_site_model.sv
// Far side of the controller: fire panel contact and assist pump starters.
// Assumes the bench commands the alarm and reads back the starter count.
`default_nettype none

module psfm_site_model (
    input  wire logic       alarm,
    input  wire logic       normally_closed,
    input  wire logic [3:0] pump_cmd,
    output logic            fire_contact,
    output logic [2:0]      pumps_running
);
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------
    // Contact wiring
    // -------------------------------------------------------------
    // A closed loop opens on alarm, an open loop closes on alarm
    assign fire_contact  = alarm ^ normally_closed;
    // Each energised starter is one running assist pump
    assign pumps_running = 3'($countones(pump_cmd));
endmodule

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the pump staging and emergency controller.
// Assumes psfm_params.svh on the include path; the one-second tick
// never elapses in this run, so settling is seen only as blocking.
`include "psfm_params.svh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, resetn = 0, sten = 1, clr = 0, pol = 0, tq_off = 0;
    logic        nrun = 0, alarm = 0, use_src = 0;
    logic [15:0] ospd = 0, espd = 0, nref = 0, rnd = 16'hD7CC, r;
    logic [15:0] start = 16'h01F4, stop = 16'h012C, ev;
    logic [9:0]  settle = 10'h03C;
    logic [2:0]  units = 3'h4, running;
    logic [3:0]  mode = 0, pump;
    logic [13:0] trip = 0, trips, tm;
    logic        emer, settled, run, arst, contact, em;
    logic [15:0] spd;
    int          errors = 0, comparisons = 0, cid, i;
    int          id_q[$];
    logic [15:0] exp_q[$];
    event        chk_ev;
    string       nm[8] = '{"pump_on_q", "emergency_active_q", "settled_q",
                           "run_cmd_q", "speed_ref_q", "trip_active_q",
                           "auto_restart_q", "pumps_running"};
    int          modes[5] = '{4, 8, 13, 0, 5};

    always #2.5 clk = ~clk;

    psfm_ctrl u_dut (.clk(clk), .resetn(resetn), .staging_enable(sten),
        .output_speed(ospd), .assist_start_speed(start),
        .assist_stop_speed(stop), .staging_settle_time(settle),
        .run_time_counter_clear(clr), .assist_unit_count(units),
        .emergency_input_polarity(pol), .emergency_speed_setting(espd),
        .control_mode_select(mode),
        .digital_input_2(use_src ? ~contact : contact),
        .emergency_input_source(use_src ? contact : ~contact),
        .safe_torque_off_input(tq_off), .normal_run_cmd(nrun),
        .normal_speed_ref(nref), .trip_request(trip), .pump_on_q(pump),
        .emergency_active_q(emer), .settled_q(settled), .run_cmd_q(run),
        .speed_ref_q(spd), .trip_active_q(trips), .auto_restart_q(arst));

    psfm_site_model u_site (.alarm(alarm), .normally_closed(pol),
        .pump_cmd(pump), .fire_contact(contact), .pumps_running(running));

    // -------------------------------------------------------------
    // Expectation queue and output monitor
    // -------------------------------------------------------------
    function automatic logic [15:0] seen(int id);
        case (id)
            0: return 16'(pump);
            1: return 16'(emer);
            2: return 16'(settled);
            3: return 16'(run);
            4: return spd;
            5: return 16'(trips);
            6: return 16'(arst);
            default: return 16'(running);
        endcase
    endfunction

    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic note(int id, logic [15:0] v);
        id_q.push_back(id);
        exp_q.push_back(v);
        -> chk_ev;
    endtask

    always @(chk_ev) begin
        while (id_q.size() > 0) begin
            cid = id_q.pop_front();
            ev  = exp_q.pop_front();
            comparisons++;
            if (seen(cid) !== ev) begin
                errors++;
                $display("MISMATCH %s expected %h seen %h", nm[cid], ev,
                         seen(cid));
            end
        end
    end

    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        begin : seq
            // Second pass resets mid-run and asks for zero units
            for (int pass = 0; pass < 2; pass++) begin
                resetn <= 1'b0;
                ospd   <= 16'h0010;
                units  <= pass ? 3'h0 : 3'h4;
                repeat (pass ? 2 : 5) @(posedge clk);
                resetn <= 1'b1;
                @(negedge clk);
                note(0, 0);
                note(2, 1);
                note(1, 0);
                note(3, 0);
                note(4, 0);
                note(5, 0);
                note(6, 0);
                @(posedge clk) ospd <= 16'h0200;
                for (i = 0; i < 4 && pump === 4'h0; i++) @(negedge clk);
                if (i == 4) begin
                    errors++;
                    $display("MISMATCH pump_on_q expected 1 seen 0");
                    disable seq;
                end
                note(0, 1);
                note(7, 1);
                note(2, 0);
                // Still above start, then below stop: both stay blocked
                repeat (20) @(posedge clk);
                ospd <= 16'h0010;
                repeat (20) @(posedge clk);
                @(negedge clk) note(0, 1);
            end
            // Activation source and polarity for control modes 4, 8, 13, 0 and 5
            foreach (modes[m]) for (int k = 0; k < 4; k++) begin
                @(posedge clk);
                mode    <= 4'(modes[m]);
                pol     <= k[1];
                alarm   <= k[0];
                use_src <= modes[m] == 0;
                repeat (3) @(posedge clk);
                @(negedge clk);
                em = k[0] && modes[m] != 5;
                note(1, 16'(em));
            end
            // Trip masking and speed override, random causes
            for (int k = 0; k < 8; k++) begin
                rnd = lfsr(rnd);
                r   = rnd;
                em  = k != 4 && k != 5;
                @(posedge clk);
                mode   <= 4'h4;
                pol    <= 1'b0;
                alarm  <= em;
                trip   <= r[13:0];
                espd   <= k < 2 ? 16'h0000 : r;
                tq_off <= k == 6 || k == 5;
                nrun   <= r[15];
                nref   <= ~r;
                clr    <= r[0];
                settle <= 10'h002 + 10'(r[8:0]);
                repeat (4) @(posedge clk);
                @(negedge clk);
                tm = em ? r[13:0] & ~`PSFM_SUPPRESS_MASK : r[13:0];
                note(5, 16'(tm));
                tm = em ? r[13:0] & `PSFM_RESTART_MASK : 14'h0000;
                note(6, 16'(|tm));
                if (k == 6 || k == 5) begin
                    note(3, 0);
                    note(4, 0);
                end else if (em && k >= 2) begin
                    note(3, 1);
                    note(4, r);
                end else begin
                    note(3, 16'(r[15]));
                    note(4, ~r);
                end
            end
        end
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule

`default_nettype wire
